// ==== inc/sbi_defines.svh ====
// register map, field positions, reset values and last-beat indices of the system bus interface
`ifndef SBI_DEFINES_SVH
`define SBI_DEFINES_SVH

// ==========================================
// register byte offsets
`define SBI_A_CFG0      6'h00
`define SBI_A_CFG1      6'h04
`define SBI_A_ADDR      6'h08
`define SBI_A_ATTR      6'h0c
`define SBI_A_GO        6'h10

// ==========================================
// hw_impl_config0 fields
`define SBI_CFG0_ABE    0
`define SBI_CFG0_CE     1
`define SBI_CFG0_RST    2'h0

// ==========================================
// hw_impl_config1 status fields
`define SBI_ST_RATIO    4:0
`define SBI_ST_BUSY     8
`define SBI_ST_RETRY    9
`define SBI_ST_DONE     10
`define SBI_ST_PINS     15:12

// ==========================================
// transfer attribute fields
`define SBI_AT_TT       4:0
`define SBI_AT_BYTES    8:5
`define SBI_AT_READ     9
`define SBI_AT_AONLY    10
`define SBI_AT_CI       11
`define SBI_AT_WT       12
`define SBI_AT_BLK      13
`define SBI_AT_RST      14'h0020

// ==========================================
// last-beat indices (beats minus one)
`define SBI_BEAT_BURST  2'h3
`define SBI_BEAT_SINGLE 2'h0

`endif

// ==== inc/sbi_pkg.sv ====
// types shared by the system bus interface
package sbi_pkg;
	typedef enum logic [2:0] {
		ST_IDLE  = 3'h0,
		ST_AREQ  = 3'h1,
		ST_ATEN  = 3'h2,
		ST_AWAIT = 3'h3,
		ST_DREQ  = 3'h4,
		ST_BEAT  = 3'h5
	} sbi_state_t;
	typedef logic [31:0] sbi_word_t;
	typedef logic [63:0] sbi_dword_t;
endpackage

// ==== hdl/sbi_bus_unit.sv ====
// system bus interface: wishbone register slave driving a decoupled address/data processor bus
//
// Our own choices: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "sbi_defines.svh"

// How it works
// - single beat moves 1,2,3,4 or 8 bytes
// - inhibited, write-through, caches-off go single-beat
// - bursts carry whole 32-byte block, four beats
// - address-only, attribute variants and retry supported
// - address-only broadcast only when enable bit set
// - io uses the same memory protocol
// - address and data tenures are separate phases
// - reads never pass stores: one command in flight at a time
// - writes may enter between read tenures
// - address tenure may overlap another data tenure
// - address and data owners may differ
// - win address bus, then pulse transfer start
// - drive type, size, burst, wt, ci attributes
// - data bus has its own arbitration
// - active-low pins asserted when low
// - 32-bit address, 5-bit type, active high
// - interrupt, checkstop, soft and hard reset inputs
// - core clock multiplier from 5-bit ratio
// - software reads the clock ratio
// - second-level misses fetched over this bus
module sbi_bus_unit (
	input  wire logic             sys_clk,
	input  wire logic             reset,
	input  wire logic             wb_cyc,
	input  wire logic             wb_stb,
	input  wire logic             wb_we,
	input  wire logic [5:0]       wb_adr,
	input  wire logic [3:0]       wb_sel,
	input  wire sbi_pkg::sbi_word_t  wb_dat_w,
	output sbi_pkg::sbi_word_t    wb_dat_r,
	output logic                  wb_ack,
	output logic                  bus_request_n,
	input  wire logic             bus_grant_n,
	output logic                  transfer_start_n,
	output logic [31:0]           address_out,
	output logic                  address_oe_n,
	output logic [4:0]            transfer_type_code,
	output logic [2:0]            transfer_size,
	output logic                  burst_n,
	output logic                  write_through_n,
	output logic                  cache_inhibit_n,
	input  wire logic             address_ack_n,
	input  wire logic             address_retry_n,
	input  wire logic             data_grant_n,
	input  wire logic             transfer_ack_n,
	input  wire sbi_pkg::sbi_dword_t data_in,
	output sbi_pkg::sbi_dword_t   data_out,
	output logic                  data_oe_n,
	input  wire logic             interrupt_n,
	input  wire logic             checkstop_n,
	input  wire logic             soft_reset_n,
	input  wire logic             hard_reset_n,
	input  wire logic [4:0]       pll_ratio,
	output logic [4:0]            core_multiplier,
	output logic                  core_interrupt,
	output logic                  core_checkstop,
	output logic                  core_soft_reset,
	output logic                  core_hard_reset
);
	import sbi_pkg::*;

	localparam int SW = 78;

	// ==========================================
	// pin synchronisers: every pin passes two flops
	logic [SW-1:0] sync1_ff;
	logic [SW-1:0] sync2_ff;
	always_ff @(posedge sys_clk) begin
		sync1_ff <= {data_in, pll_ratio, hard_reset_n, soft_reset_n, checkstop_n, interrupt_n,
			transfer_ack_n, data_grant_n, address_retry_n, address_ack_n, bus_grant_n};
		sync2_ff <= sync1_ff;
	end

	logic       bg_s, aack_s, retry_s, dbg_s, ta_s;
	logic [3:0] pins_s;
	logic [4:0] ratio_s;
	sbi_dword_t din_s;
	// active-low pins are decoded here once
	assign bg_s    = !sync2_ff[0];
	assign aack_s  = !sync2_ff[1];
	assign retry_s = !sync2_ff[2];
	assign dbg_s   = !sync2_ff[3];
	assign ta_s    = !sync2_ff[4];
	assign pins_s  = ~sync2_ff[8:5];
	assign ratio_s = sync2_ff[13:9];
	assign din_s   = sync2_ff[77:14];

	// ==========================================
	// helpers
	function automatic sbi_word_t merge(input sbi_word_t old, input sbi_word_t nw, input logic [3:0] sel);
		merge = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				merge[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
	endfunction

	// ==========================================
	// state
	sbi_state_t st_ff;
	logic [1:0] cfg0_ff;
	logic [13:0] attr_ff;
	logic [31:0] addr_ff;
	sbi_dword_t buf_mem [4];
	logic [1:0] beat_ff;
	logic [1:0] last_ff;
	logic       retried_ff;
	logic       done_ff;
	logic [4:0] ratio_ff;
	logic       cap_ff;
	logic       ack_ff;
	sbi_word_t  rd_ff;

	logic wb_req, wr, go, busy, aonly_skip, burst_sel;
	sbi_word_t rd_ff_next;
	sbi_word_t cfg0_wr;
	sbi_word_t attr_wr;
	assign cfg0_wr = merge({30'h0, cfg0_ff}, wb_dat_w, wb_sel);
	assign attr_wr = merge({18'h0, attr_ff}, wb_dat_w, wb_sel);
	assign wb_req = wb_cyc && wb_stb && !ack_ff;
	assign wr     = wb_req && wb_we;
	assign busy   = st_ff != ST_IDLE;
	assign go     = wr && wb_adr[5:2] == `SBI_A_GO >> 2 && wb_sel[0] && !busy;
	// address-only traffic stays off the bus unless broadcast is enabled
	assign aonly_skip = attr_ff[`SBI_AT_AONLY] && !cfg0_ff[`SBI_CFG0_ABE];
	// whole cached blocks burst; inhibited, write-through or caches-off go single
	assign burst_sel = attr_ff[`SBI_AT_BLK] && !attr_ff[`SBI_AT_CI] && !attr_ff[`SBI_AT_WT]
		&& cfg0_ff[`SBI_CFG0_CE];

	// ==========================================
	// wishbone slave: answers one edge after the request, every address
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			ack_ff <= 1'b0;
		end else begin
			ack_ff <= wb_req;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			cfg0_ff <= `SBI_CFG0_RST;
			attr_ff <= `SBI_AT_RST;
			addr_ff <= 32'h0;
		end else if (wr && !busy) begin
			// attributes are frozen while a transfer runs
			unique case (wb_adr[5:2])
				`SBI_A_CFG0 >> 2: cfg0_ff <= cfg0_wr[1:0];
				`SBI_A_ADDR >> 2: addr_ff <= merge(addr_ff, wb_dat_w, wb_sel);
				`SBI_A_ATTR >> 2: attr_ff <= attr_wr[13:0];
				default: ;
			endcase
		end
	end

	always_comb begin
		rd_ff_next = 32'h0;
		if (wb_adr[5]) begin
			rd_ff_next = wb_adr[2] ? buf_mem[wb_adr[4:3]][63:32] : buf_mem[wb_adr[4:3]][31:0];
		end else begin
			unique case (wb_adr[4:2])
				3'h0: rd_ff_next = {30'h0, cfg0_ff};
				3'h1: begin
					rd_ff_next[`SBI_ST_RATIO] = ratio_ff;
					rd_ff_next[`SBI_ST_BUSY]  = busy;
					rd_ff_next[`SBI_ST_RETRY] = retried_ff;
					rd_ff_next[`SBI_ST_DONE]  = done_ff;
					rd_ff_next[`SBI_ST_PINS]  = pins_s;
				end
				3'h2: rd_ff_next = addr_ff;
				3'h3: rd_ff_next = {18'h0, attr_ff};
				default: rd_ff_next = 32'h0;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			rd_ff <= 32'h0;
		end else if (wb_req && !wb_we) begin
			rd_ff <= rd_ff_next;
		end
	end
	assign wb_ack   = ack_ff;
	assign wb_dat_r = rd_ff;

	// ==========================================
	// transfer engine
	logic       br_n_ff, ts_n_ff, aoe_n_ff, doe_n_ff;
	logic       tbst_n_ff, wt_n_ff, ci_n_ff;
	logic [4:0] tt_ff;
	logic [2:0] tsiz_ff;
	logic [31:0] aout_ff;
	logic [1:0] nxt_beat;
	sbi_dword_t dout_ff;

	assign nxt_beat = (st_ff == ST_BEAT && ta_s) ? beat_ff + 2'h1 : (st_ff == ST_BEAT ? beat_ff : 2'h0);

	// io and memory follow the same sequence; the command word only carries a type code
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			st_ff <= ST_IDLE;
			br_n_ff <= 1'b1;
			ts_n_ff <= 1'b1;
			aoe_n_ff <= 1'b1;
			doe_n_ff <= 1'b1;
			beat_ff <= 2'h0;
			last_ff <= 2'h0;
			retried_ff <= 1'b0;
			done_ff <= 1'b0;
		end else begin
			unique case (st_ff)
				ST_IDLE: begin
					if (go) begin
						retried_ff <= 1'b0;
						done_ff <= aonly_skip;
						last_ff <= burst_sel ? `SBI_BEAT_BURST : `SBI_BEAT_SINGLE;
						if (!aonly_skip) begin
							st_ff <= ST_AREQ;
							br_n_ff <= 1'b0;
						end
					end
				end
				ST_AREQ: begin
					// any grant policy is fine: wait as long as it takes
					if (bg_s) begin
						st_ff <= ST_ATEN;
						br_n_ff <= 1'b1;
						ts_n_ff <= 1'b0;
						aoe_n_ff <= 1'b0;
					end
				end
				ST_ATEN: begin
					ts_n_ff <= 1'b1;
					st_ff <= ST_AWAIT;
				end
				ST_AWAIT: begin
					if (retry_s) begin
						st_ff <= ST_AREQ;
						br_n_ff <= 1'b0;
						aoe_n_ff <= 1'b1;
						retried_ff <= 1'b1;
					end else if (aack_s) begin
						// address bus freed here, so another address tenure may overlap our data
						aoe_n_ff <= 1'b1;
						if (attr_ff[`SBI_AT_AONLY]) begin
							st_ff <= ST_IDLE;
							done_ff <= 1'b1;
						end else begin
							st_ff <= ST_DREQ;
						end
					end
				end
				ST_DREQ: begin
					if (dbg_s) begin
						st_ff <= ST_BEAT;
						beat_ff <= 2'h0;
						doe_n_ff <= attr_ff[`SBI_AT_READ];
					end
				end
				ST_BEAT: begin
					if (ta_s) begin
						beat_ff <= nxt_beat;
						if (beat_ff == last_ff) begin
							st_ff <= ST_IDLE;
							doe_n_ff <= 1'b1;
							done_ff <= 1'b1;
						end
					end
				end
				default: st_ff <= ST_IDLE;
			endcase
		end
	end

	// attributes ride with the address; one command in flight keeps load/store order.
	// a block fetch after a second-level miss is a burst read issued here
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			aout_ff <= 32'h0;
			tt_ff <= 5'h0;
			tsiz_ff <= 3'h0;
			tbst_n_ff <= 1'b1;
			wt_n_ff <= 1'b1;
			ci_n_ff <= 1'b1;
		end else if (st_ff == ST_AREQ && bg_s) begin
			aout_ff <= addr_ff;
			tt_ff <= attr_ff[`SBI_AT_TT];
			// 8 bytes encodes as zero
			tsiz_ff <= attr_ff[`SBI_AT_BYTES] >= 4'h8 ? 3'h0 : attr_ff[7:5];
			tbst_n_ff <= last_ff != `SBI_BEAT_BURST;
			wt_n_ff <= !attr_ff[`SBI_AT_WT];
			ci_n_ff <= !attr_ff[`SBI_AT_CI];
		end
	end

	// data buffer: software fills/reads it, read beats land in it
	always_ff @(posedge sys_clk) begin
		if (st_ff == ST_BEAT && ta_s && attr_ff[`SBI_AT_READ]) begin
			buf_mem[beat_ff] <= din_s;
		end else if (wr && !busy && wb_adr[5]) begin
			if (wb_adr[2]) begin
				buf_mem[wb_adr[4:3]][63:32] <= merge(buf_mem[wb_adr[4:3]][63:32], wb_dat_w, wb_sel);
			end else begin
				buf_mem[wb_adr[4:3]][31:0] <= merge(buf_mem[wb_adr[4:3]][31:0], wb_dat_w, wb_sel);
			end
		end
	end

	// look one beat ahead so the next word is on the pins when the beat advances
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			dout_ff <= 64'h0;
		end else begin
			dout_ff <= buf_mem[nxt_beat];
		end
	end

	// ==========================================
	// clock ratio strap and core control pins
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			cap_ff <= 1'b1;
			ratio_ff <= 5'h0;
		end else if (cap_ff) begin
			cap_ff <= 1'b0;
			ratio_ff <= ratio_s;
		end
	end

	logic [3:0] core_ff;
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			core_ff <= 4'h0;
		end else begin
			core_ff <= pins_s;
		end
	end

	assign bus_request_n      = br_n_ff;
	assign transfer_start_n   = ts_n_ff;
	assign address_out        = aout_ff;
	assign address_oe_n       = aoe_n_ff;
	assign transfer_type_code = tt_ff;
	assign transfer_size      = tsiz_ff;
	assign burst_n            = tbst_n_ff;
	assign write_through_n    = wt_n_ff;
	assign cache_inhibit_n    = ci_n_ff;
	assign data_out           = dout_ff;
	assign data_oe_n          = doe_n_ff;
	assign core_multiplier    = ratio_ff;
	assign {core_hard_reset, core_soft_reset, core_checkstop, core_interrupt} = core_ff;

	// ==========================================
	// checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	a_ts_after_grant: assert property (!ts_n_ff |-> $past(bg_s) && $past(st_ff) == ST_AREQ)
		else $error("transfer start without address grant");
	a_ts_one_cycle: assert property ($fell(ts_n_ff) |=> ts_n_ff && st_ff == ST_AWAIT)
		else $error("transfer start longer than one cycle");
	a_addr_granted: assert property (!aoe_n_ff |-> st_ff inside {ST_ATEN, ST_AWAIT})
		else $error("address driven outside tenure");
	a_data_granted: assert property ($fell(doe_n_ff) |-> $past(dbg_s) && st_ff == ST_BEAT)
		else $error("data driven before data grant");
	a_single_attr: assert property (!ts_n_ff && (!ci_n_ff || !wt_n_ff) |-> burst_n)
		else $error("inhibited or write-through transfer bursted");
	a_burst_four: assert property (st_ff == ST_BEAT && ta_s && beat_ff == 2'h3 |=> st_ff == ST_IDLE)
		else $error("burst not ended after fourth beat");
	a_abe_gate: assert property (go && aonly_skip |=> st_ff == ST_IDLE && done_ff)
		else $error("address-only broadcast while disabled");
	a_retry_rearb: assert property (st_ff == ST_AWAIT && retry_s |=> !br_n_ff && aoe_n_ff ##1 st_ff == ST_AREQ)
		else $error("retry did not re-arbitrate");
	a_ratio_held: assert property (!cap_ff && !$past(cap_ff) |-> $stable(ratio_ff))
		else $error("ratio changed after capture");
	a_single_end: assert property (st_ff == ST_BEAT && ta_s && last_ff == 2'h0 |=> doe_n_ff && st_ff == ST_IDLE)
		else $error("single beat did not end tenure");
	a_ack_pulse: assert property (wb_ack |=> !wb_ack)
		else $error("ack held two cycles");

	c_burst_done: cover property (st_ff == ST_BEAT && ta_s && beat_ff == 2'h3);
	c_retry: cover property (st_ff == ST_AWAIT && retry_s);
	c_aonly: cover property (st_ff == ST_AWAIT && aack_s && attr_ff[`SBI_AT_AONLY]);
endmodule

// ==== bench/sbi_far_side.sv ====
// far side model: arbiter, memory controller and data source of the processor bus
`timescale 1ns/1ps
module sbi_far_side (
	input  wire logic          sys_clk,
	input  wire logic          reset,
	input  wire logic          bus_request_n,
	input  wire logic          transfer_start_n,
	input  wire logic          burst_n,
	input  wire logic          no_data,
	input  wire logic          slow,
	input  wire logic          retry_once,
	output logic               bus_grant_n,
	output logic               address_ack_n,
	output logic               address_retry_n,
	output logic               data_grant_n,
	output logic               transfer_ack_n,
	output sbi_pkg::sbi_dword_t data_in,
	output int                 n_ta
);
	import sbi_pkg::*;
	// =====
	// grant, terminate, beats
	int   ph;
	int   cnt;
	int   k;
	int   j;
	logic tried;
	always @(posedge sys_clk) begin
		// released data lines keep moving so stale beats cannot pass
		data_in <= ~data_in;
		address_ack_n <= 1'b1;
		address_retry_n <= 1'b1;
		transfer_ack_n <= 1'b1;
		if (!retry_once)
			tried <= 1'b0;
		if (reset) begin
			ph <= 0;
			cnt <= 0;
			n_ta <= 0;
			bus_grant_n <= 1'b1;
			data_grant_n <= 1'b1;
			data_in <= '0;
		end else case (ph)
			0: if (!bus_request_n) begin
				cnt <= cnt + 1;
				if (cnt >= (slow ? 5 : 1)) begin
					bus_grant_n <= 1'b0;
					cnt <= 0;
					ph <= 1;
				end
			end
			1: if (!transfer_start_n) begin
				bus_grant_n <= 1'b1;
				k <= burst_n ? 1 : 4;
				j <= 0;
				ph <= 2;
			end
			2: begin
				cnt <= cnt + 1;
				if (cnt >= (slow ? 5 : 1) && retry_once && !tried) begin
					address_retry_n <= 1'b0;
					tried <= 1'b1;
					cnt <= 0;
					ph <= 0;
				end else if (cnt >= (slow ? 5 : 1)) begin
					address_ack_n <= 1'b0;
					cnt <= 0;
					ph <= no_data ? 0 : 3;
				end
			end
			3: begin
				data_grant_n <= 1'b0;
				cnt <= cnt + 1;
				// beats spaced past the design's two-flop input lag
				if (cnt >= 3) begin
					transfer_ack_n <= 1'b0;
					data_in <= {32'h0c0ffee0, 32'(j)};
					n_ta <= n_ta + 1;
					j <= j + 1;
					cnt <= 0;
					if (j == k - 1) begin
						data_grant_n <= 1'b1;
						ph <= 0;
					end
				end
			end
			default: ph <= 0;
		endcase
	end
endmodule

// ==== bench/testbench.sv ====
// register-level tests of the system bus interface against the far side model
`timescale 1ns/1ps
`include "sbi_defines.svh"
module testbench;
	import sbi_pkg::*;
	// =====
	// signals
	logic        sys_clk, reset, wb_cyc, wb_stb, wb_we, wb_ack, no_data, slow, retry_once;
	logic [5:0]  wb_adr;
	logic [3:0]  wb_sel, pins_n;
	sbi_word_t   wb_dat_w, wb_dat_r, q, st;
	logic        bus_request_n, bus_grant_n, transfer_start_n, address_oe_n, burst_n, data_oe_n;
	logic        write_through_n, cache_inhibit_n, address_ack_n, address_retry_n, data_grant_n;
	logic        transfer_ack_n, interrupt_n, checkstop_n, soft_reset_n, hard_reset_n;
	logic        core_interrupt, core_checkstop, core_soft_reset, core_hard_reset;
	logic [31:0] address_out, ts_adr;
	logic [4:0]  transfer_type_code, pll_ratio, core_multiplier, ts_tt;
	logic [2:0]  transfer_size, ts_sz;
	logic        ts_b, ts_ci, ts_wt;
	sbi_dword_t  data_in, data_out;
	int          n_ta, n_ts, n_mismatch, total_checks, i;
	logic [3:0]  nb [5] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h8};
	logic [2:0]  sz [5] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h0};
	assign {hard_reset_n, soft_reset_n, checkstop_n, interrupt_n} = pins_n;
	sbi_bus_unit dut (.*);
	sbi_far_side far (.*);
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) if (!reset && transfer_start_n === 1'b0) begin
		n_ts <= n_ts + 1;
		ts_adr <= address_out;
		ts_tt <= transfer_type_code;
		ts_sz <= transfer_size;
		ts_b <= burst_n;
		ts_ci <= cache_inhibit_n;
		ts_wt <= write_through_n;
		chk(32'(bus_grant_n), 0);
		chk(32'(address_oe_n), 0);
	end
	// =====
	// access tasks
	task automatic chk(input sbi_word_t got, input sbi_word_t exp);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic we, input logic [5:0] a, input sbi_word_t d);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= a;
		wb_dat_w <= d;
		do @(posedge sys_clk); while (wb_ack !== 1'b1);
		q = wb_dat_r;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic rdc(input logic [5:0] a, input sbi_word_t e);
		wb(1'b0, a, 0);
		chk(q, e);
	endtask
	function automatic sbi_word_t at(input logic [4:0] tt, input logic [3:0] n, input logic [4:0] f);
		at = 32'h0;
		at[`SBI_AT_TT] = tt;
		at[`SBI_AT_BYTES] = n;
		at[`SBI_AT_BLK:`SBI_AT_READ] = f;
	endfunction
	task automatic xfer(input sbi_word_t a, input sbi_word_t atr, input logic nd, input logic rt, input int ets,
		input int eta);
		int t0;
		int a0;
		int p;
		t0 = n_ts;
		a0 = n_ta;
		no_data <= nd;
		retry_once <= rt;
		wb(1'b1, `SBI_A_ADDR, a);
		wb(1'b1, `SBI_A_ATTR, atr);
		wb(1'b1, `SBI_A_GO, 0);
		// poll fresh status: q still holds the previous command's done bit
		p = 0;
		do begin
			wb(1'b0, `SBI_A_CFG1, 0);
			p++;
		end while (p < 300 && q[`SBI_ST_DONE] !== 1'b1);
		st = q;
		chk(32'(st[`SBI_ST_DONE]), 1);
		chk(32'(n_ts - t0), 32'(ets));
		chk(32'(n_ta - a0), 32'(eta));
		if (ets > 0)
			chk(ts_adr, a);
	endtask
	task close_out;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// =====
	// tests
	initial begin
		n_ts = 0;
		n_mismatch = 0;
		total_checks = 0;
		{wb_cyc, wb_stb, wb_we, wb_adr, wb_dat_w} = '0;
		wb_sel = 4'hf;
		pins_n = 4'hf;
		pll_ratio = 5'h0b;
		{no_data, slow, retry_once} = 3'h0;
		reset = 1'b1;
		repeat (12) @(posedge sys_clk);
		reset <= 1'b0;
		@(posedge sys_clk);
		rdc(`SBI_A_CFG0, 0);
		rdc(`SBI_A_ATTR, `SBI_AT_RST);
		rdc(`SBI_A_CFG1, 32'(pll_ratio));
		chk(32'(core_multiplier), 32'(pll_ratio));
		rdc(6'h18, 0);
		for (i = 0; i < 5; i++) begin
			xfer(32'h40000100 + 32'(i), at(5'h02, nb[i], 5'h00), 0, 0, 1, 1);
			chk(32'(ts_sz), 32'(sz[i]));
			chk(32'(ts_tt), 32'h2);
			chk(32'(ts_b), 1);
		end
		wb(1'b1, `SBI_A_CFG0, 32'h2);
		slow <= 1'b1;
		xfer(32'h00002000, at(5'h0a, 4'h8, 5'h11), 0, 0, 1, 4);
		chk(32'(ts_b), 0);
		for (i = 0; i < 4; i++) begin
			rdc(6'h20 + 6'(8 * i), 32'(i));
			rdc(6'h24 + 6'(8 * i), 32'h0c0ffee0);
		end
		slow <= 1'b0;
		xfer(32'h00003000, at(5'h0a, 4'h8, 5'h15), 0, 0, 1, 1);
		chk(32'(ts_ci), 0);
		xfer(32'h00003020, at(5'h06, 4'h8, 5'h18), 0, 0, 1, 1);
		chk(32'(ts_wt), 0);
		wb(1'b1, `SBI_A_CFG0, 32'h0);
		xfer(32'h00003040, at(5'h0a, 4'h8, 5'h11), 0, 0, 1, 1);
		xfer(32'h00005000, at(5'h02, 4'h4, 5'h00), 0, 1, 2, 1);
		chk(32'(st[`SBI_ST_RETRY]), 1);
		xfer(32'h00006000, at(5'h16, 4'h1, 5'h02), 1, 0, 0, 0);
		wb(1'b1, `SBI_A_CFG0, 32'h1);
		xfer(32'h00006000, at(5'h16, 4'h1, 5'h02), 1, 0, 1, 0);
		for (i = 0; i < 4; i++) begin
			pins_n <= ~(4'h1 << i);
			repeat (5) @(posedge sys_clk);
			chk(32'({core_hard_reset, core_soft_reset, core_checkstop, core_interrupt}), 32'(4'h1 << i));
			wb(1'b0, `SBI_A_CFG1, 0);
			chk(32'(q[`SBI_ST_PINS]), 32'(4'h1 << i));
		end
		pins_n <= 4'hf;
		close_out;
	end
	initial begin
		#400000;
		n_mismatch++;
		close_out;
	end
endmodule
